// ### rtl/blcr_load_readout.sv
`timescale 1ns/1ps
// Overview of operation
// - Each write to the select register starts a new load current measurement.
// - Select bit 0 picks converter: 0 first, 1 second.
// - Upper result register holds result bit 8 at bit 0; bits 7:1 read zero.
// - Lower result register holds result bits 7:0.
// - Result is scaled 20 mA per step, 10.22 A at full scale.
`include "blcr_params.svh"

module blcr_load_readout
    import blcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // Current sensing front end
    output logic measStart,
    output logic measConverter,
    input wire logic measDone,
    input wire logic [8:0] measValue,
    // Status
    output logic measBusy,
    output logic [13:0] loadCurrentMa
);

    // Register state
    logic [7:0] selectReg_ff;
    logic [7:0] nxt_select;
    blcr_result_t result_ff;
    blcr_result_t nxt_result;
    logic [13:0] currentMa_ff;
    logic [13:0] nxt_currentMa;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;

    // Measurement control
    blcr_state_t state_ff;
    blcr_state_t nxt_state;
    logic measStart_ff;
    logic nxt_measStart;
    logic busy_ff;
    logic nxt_busy;

    // Decoded strobes
    logic selWrite;
    logic doneTake;

    function automatic logic isSelectWrite(input logic [7:0] addr, input logic wrEn);
        logic hit;
        hit = wrEn && (addr == `BLCR_OFS_SELECT);
        return hit;
    endfunction

    // Completion counts only while busy, outside the start cycle and a new write
    function automatic logic acceptDone(input blcr_state_t state, input logic done,
                                        input logic startCycle, input logic newWrite);
        logic take;
        take = (state == BLCR_BUSY) && done && !startCycle && !newWrite;
        return take;
    endfunction

    function automatic logic [13:0] scaleToMa(input blcr_result_t code);
        logic [13:0] wide;
        wide = 14'({5'h00, code}) * `BLCR_LSB_MA;
        return wide;
    endfunction

    // Upper result view, reserved bits forced low
    function automatic logic [7:0] highView(input blcr_result_t res);
        logic [7:0] data;
        data = 8'h00;
        data[`BLCR_HIGH_BIT] = res[`BLCR_RESULT_MSB];
        return data;
    endfunction

    function automatic logic [7:0] lowView(input blcr_result_t res);
        logic [7:0] data;
        data = res[7:0];
        return data;
    endfunction

    function automatic logic [7:0] readMux(input logic [7:0] addr, input logic [7:0] sel,
                                           input blcr_result_t res);
        logic [7:0] data;
        data = 8'h00;
        case (addr)
            `BLCR_OFS_SELECT: data = sel;
            `BLCR_OFS_HIGH: data = highView(res);
            `BLCR_OFS_LOW: data = lowView(res);
            default: data = 8'h00;
        endcase
        return data;
    endfunction

    // Strobes decoded once, shared by state and result logic
    assign selWrite = isSelectWrite(regAddr, regWrEn);
    assign doneTake = acceptDone(state_ff, measDone, measStart_ff, selWrite);

    // Select register, reserved bits stored as written
    always_comb begin
        nxt_select = selectReg_ff;
        if (selWrite) begin
            nxt_select = regWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            selectReg_ff <= `BLCR_SELECT_RST;
        end else begin
            selectReg_ff <= nxt_select;
        end
    end

    // One start pulse per write, even while busy
    always_comb begin
        nxt_measStart = 1'b0;
        if (selWrite) begin
            nxt_measStart = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            measStart_ff <= 1'b0;
        end else begin
            measStart_ff <= nxt_measStart;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            BLCR_IDLE: begin
                if (selWrite) begin
                    nxt_state = BLCR_BUSY;
                end
            end
            BLCR_BUSY: begin
                if (selWrite) begin
                    nxt_state = BLCR_BUSY;
                end else if (doneTake) begin
                    nxt_state = BLCR_IDLE;
                end
            end
            default: nxt_state = BLCR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= BLCR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Busy port kept in its own flop, mirrors the next state
    always_comb begin
        nxt_busy = 1'b0;
        if (nxt_state == BLCR_BUSY) begin
            nxt_busy = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    // Both result registers move on one edge
    always_comb begin
        nxt_result = result_ff;
        nxt_currentMa = currentMa_ff;
        if (doneTake) begin
            nxt_result = measValue;
            nxt_currentMa = scaleToMa(measValue);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            result_ff <= `BLCR_RESULT_RST;
            currentMa_ff <= `BLCR_MA_RST;
        end else begin
            result_ff <= nxt_result;
            currentMa_ff <= nxt_currentMa;
        end
    end

    // Read data stands until the next read
    always_comb begin
        nxt_rdData = rdData_ff;
        if (regRdEn) begin
            nxt_rdData = readMux(regAddr, selectReg_ff, result_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_ff <= 8'h00;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // Ports straight from flops
    assign regRdData = rdData_ff;
    assign measStart = measStart_ff;
    assign measConverter = selectReg_ff[`BLCR_SEL_BIT];
    assign measBusy = busy_ff;
    assign loadCurrentMa = currentMa_ff;

endmodule

// ### rtl/blcr_params.svh
`ifndef BLCR_PARAMS_SVH
`define BLCR_PARAMS_SVH

// Register offsets
`define BLCR_OFS_SELECT 8'h24
`define BLCR_OFS_HIGH 8'h25
`define BLCR_OFS_LOW 8'h26

// Field positions
`define BLCR_SEL_BIT 0
`define BLCR_HIGH_BIT 0
`define BLCR_RESULT_MSB 8

// Reset values
`define BLCR_SELECT_RST 8'h00
`define BLCR_RESULT_RST 9'h000
`define BLCR_MA_RST 14'h0000

// Scale of one result step in mA
`define BLCR_LSB_MA 14'h0014

`endif

// ### rtl/blcr_pkg.sv
package blcr_pkg;

    typedef enum logic [0:0] {
        BLCR_IDLE = 1'b0,
        BLCR_BUSY = 1'b1
    } blcr_state_t;

    typedef logic [8:0] blcr_result_t;

endpackage

// ### test/blcr_properties.sv
`timescale 1ns/1ps
module blcr_properties (
    input wire logic clk, rst, regWrEn, regRdEn, measStart, measConverter, measDone, measBusy,
    input wire logic [7:0] regAddr, regWrData, regRdData,
    input wire logic [8:0] measValue,
    input wire logic [13:0] loadCurrentMa
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wr_start_a: assert property (regWrEn && regAddr == 8'h24
        |=> measStart && measBusy) else $error("no start");
    conv_sel_a: assert property (regWrEn && regAddr == 8'h24
        |=> measConverter == $past(regWrData[0])) else $error("bad converter");
    high_read_a: assert property (regRdEn && regAddr == 8'h25
        |=> regRdData == {7'h00, $past(loadCurrentMa) >= 14'h1400}) else $error("bad high");
    low_read_a: assert property (regRdEn && regAddr == 8'h26
        |=> regRdData == 8'($past(loadCurrentMa) / 14'h0014)) else $error("bad low");
    ma_scale_a: assert property (measDone && measBusy && !measStart && !regWrEn
        |=> !measBusy && loadCurrentMa == $past(measValue) * 14'h0014) else $error("bad mA");
    result_hold_a: assert property (!(measDone && measBusy)
        |=> $stable(loadCurrentMa)) else $error("result moved");
endmodule
bind blcr_load_readout blcr_properties cp (.clk, .rst, .regWrEn, .regRdEn, .measStart,
    .measConverter, .measDone, .measBusy, .regAddr, .regWrData, .regRdData, .measValue,
    .loadCurrentMa);

// ### test/blcr_fe.sv
`timescale 1ns/1ps
module blcr_fe (
    input wire logic clk, rst, measStart,
    input wire logic [8:0] code,
    output logic measDone,
    output logic [8:0] measValue
);
    logic [1:0] cnt_ff;
    always_ff @(posedge clk)
        cnt_ff <= rst ? 2'h0 : measStart ? 2'h2 : cnt_ff - {1'b0, cnt_ff != 2'h0};
    assign measDone = cnt_ff == 2'h1;
    // Value off the line outside the done cycle
    assign measValue = measDone ? code : ~code;
endmodule

// ### test/blcr_load_readout_tb.sv
`timescale 1ns/1ps
module blcr_load_readout_tb;
    logic clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, measStart, measConverter, measDone, measBusy;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [8:0] code = 9'h000, measValue;
    logic [13:0] loadCurrentMa;
    int n_mismatch = 0, tests_run = 0;
    always #10 clk = ~clk;
    blcr_load_readout blcr_load_readout_i (.clk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .measStart, .measConverter, .measDone, .measValue, .measBusy, .loadCurrentMa);
    blcr_fe blcr_fe_i (.clk, .rst, .measStart, .code, .measDone, .measValue);
    task chk(string n, logic [13:0] e, logic [13:0] s);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
        chk("regRdData", {6'h00, e}, {6'h00, regRdData});
    endtask
    task meas(logic [7:0] s, logic [8:0] c);
        code <= c;
        wr(8'h24, s);
        @(negedge clk);
        chk("measBusy", 14'h0001, {13'h0000, measBusy});
        for (int i = 0; i < 20 && measBusy !== 1'b0; i++) @(negedge clk);
        if (measBusy !== 1'b0) begin
            n_mismatch++;
            test_done;
        end
        chk("measConverter", {13'h0000, s[0]}, {13'h0000, measConverter});
        chk("loadCurrentMa", c * 14'h0014, loadCurrentMa);
        $display("measurement test ended");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h24, 8'h00);
        meas(8'h01, 9'h1ff);
        rd(8'h25, 8'h01);
        rd(8'h26, 8'hff);
        meas(8'h00, 9'h0a5);
        rd(8'h25, 8'h00);
        code <= 9'h100;
        wr(8'h24, 8'h01);
        rd(8'h26, 8'ha5);
        rd(8'h25, 8'h01);
        rd(8'h26, 8'h00);
        code <= 9'h033;
        wr(8'h24, 8'h00);
        meas(8'h01, 9'h033);
        rd(8'h30, 8'h00);
        test_done;
    end
endmodule
